// [src/bss_switchover.sv]
/*
 * Backup supply switchover controller: mode decode, supply selection,
 * return debounce, backup flag, I2C and clock-out gating, charger control.
 * Assumes comparator outputs and the event pin are asynchronous levels,
 * and that interrupt, clock source and other inputs are on ref_clk.
 * The power switch itself, the charger resistor network and the serial
 * interface sit outside; this block only tells them what to do.
 * Register offsets and field positions come from the package.
 */
// The implementer's own choices: register access over Wishbone and the address map.
`default_nettype none

module bss_switchover
	import bss_pkg::*;
#(
	parameter int DIR_DELAY = DIR_REACT_CYC,
	parameter int LVL_DELAY = LVL_REACT_CYC
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        srst,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Supply comparators, asynchronous
	input  wire logic        mainBelowBackup,
	input  wire logic        mainBelowThreshold,
	input  wire logic        backupAboveThreshold,
	// Event input pin, asynchronous
	input  wire logic        eventPin,
	// Same-domain sources
	input  wire logic        otherIrq,
	input  wire logic        clkSource,
	// Outputs
	output logic             irqOut,
	output logic             eventLevel,
	output logic             clkOutPin,
	output logic             i2cHighZ,
	output logic             i2cHoldReset,
	output logic             onBackup,
	output logic             standby,
	output logic             tsTrigger,
	output logic             clkAutoStart,
	output logic             chargerOn,
	output logic      [1:0]  chargerRes,
	output logic             fastEdgeEnable
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		// Supply state and control register copy
		bss_state_t         st;
		logic [1:0]         mode;
		logic               irqEn;
		logic               fastEdge;
		logic               chgEn;
		logic [1:0]         chgRes;
		logic               clkAuto;
		logic               tsSel;
		// Mode reaction, debounce and settle timers
		logic [1:0]         effMode;
		logic [REACT_W-1:0] reactCnt;
		logic [DEB_W-1:0]   debCnt;
		logic [1:0]         initCnt;
		// Backup switch flag
		logic               flag;
		// Synchronizers and filtered levels
		logic [2:0]         syA;
		logic [2:0]         syB;
		logic [2:0]         syC;
		logic [2:0]         syE;
		logic               mLow;
		logic               tLow;
		logic               bHigh;
		logic               evt;
		// Bus answer
		logic               ack;
		logic [31:0]        rdat;
		// Output registers
		logic               irq;
		logic               clkPin;
		logic               onBk;
		logic               stby;
		logic               ts;
		logic               clkStart;
		logic               chgOn;
	} bss_regs_t;

	bss_regs_t q;
	bss_regs_t d;

	logic                   switchCond;
	logic                   slowStart;
	logic [REACT_W-1:0]     reactLim;
	logic                   wrTake;
	logic                   rdTake;
	logic [31:0]            ctrlView;
	logic [31:0]            statView;

	// ------------------------------------------------------------
	// Supply selection
	// ------------------------------------------------------------
	// Only the effective mode counts, so a freshly written mode cannot
	// move the supply before its reaction time has passed
	always_comb begin
		case (bss_mode_t'(q.effMode))
			MODE_DIRECT: switchCond = q.mLow;
			MODE_LEVEL:  switchCond = q.mLow & q.tLow & q.bHigh;
			default:     switchCond = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// Reaction delay
	// ------------------------------------------------------------
	// Leaving off or standby for a switching mode takes time to settle;
	// the limit follows the mode being entered, not the one being left
	always_comb begin
		slowStart = q.mode[0] & ~q.effMode[0];
		if (q.mode[1]) begin
			reactLim = REACT_W'(LVL_DELAY - 1);
		end else begin
			reactLim = REACT_W'(DIR_DELAY - 1);
		end
	end

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	// A read is taken on the first cycle of a request; a write lands on
	// the cycle that carries ack, while the master still holds its data
	always_comb begin
		wrTake = wb_cyc_i & wb_stb_i & wb_we_i & q.ack;
		rdTake = wb_cyc_i & wb_stb_i & ~q.ack;
	end

	// ------------------------------------------------------------
	// Register views
	// ------------------------------------------------------------
	// Unused bits read as zero
	always_comb begin
		ctrlView  = '0;
		ctrlView[CTRL_MODE_LSB +: 2] = q.mode;
		ctrlView[CTRL_IRQ_EN]        = q.irqEn;
		ctrlView[CTRL_FAST_EDGE]     = q.fastEdge;
		ctrlView[CTRL_CHG_EN]        = q.chgEn;
		ctrlView[CTRL_RES_LSB +: 2]  = q.chgRes;
		ctrlView[CTRL_CLK_AUTO]      = q.clkAuto;
		ctrlView[CTRL_TS_SEL]        = q.tsSel;
		statView  = '0;
		statView[STAT_FLAG]          = q.flag;
		statView[STAT_ON_BACKUP]     = q.onBk;
		statView[STAT_STANDBY]       = q.stby;
		statView[STAT_PENDING]       = (q.mode != q.effMode);
		statView[STAT_EFF_LSB +: 2]  = q.effMode;
		statView[STAT_EVENT]         = q.evt;
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		d = q;
		d.ts       = 1'b0;
		d.clkStart = 1'b0;

		// Three-stage synchronizers; a level counts once stages two and three agree
		// The first stage may go metastable, so nothing else reads it
		d.syA = {q.syA[1:0], mainBelowBackup};
		d.syB = {q.syB[1:0], mainBelowThreshold};
		d.syC = {q.syC[1:0], backupAboveThreshold};
		d.syE = {q.syE[1:0], eventPin};
		if (q.syA[1] == q.syA[2]) begin
			d.mLow = q.syA[2];
		end
		if (q.syB[1] == q.syB[2]) begin
			d.tLow = q.syB[2];
		end
		if (q.syC[1] == q.syC[2]) begin
			d.bHigh = q.syC[2];
		end
		if (q.syE[1] == q.syE[2]) begin
			d.evt = q.syE[2];
		end

		// Wishbone: ack one cycle after the request, write at the ack edge
		// Unmapped reads return zero; unmapped writes are dropped
		d.ack = rdTake;
		if (rdTake) begin
			case (wb_adr_i)
				CTRL_OFS:   d.rdat = ctrlView;
				STATUS_OFS: d.rdat = statView;
				default:    d.rdat = '0;
			endcase
		end
		// Lane zero carries bits 7:0, lane one the time stamp select
		if (wrTake && wb_adr_i == CTRL_OFS) begin
			if (wb_sel_i[0]) begin
				d.mode     = wb_dat_i[CTRL_MODE_LSB +: 2];
				d.irqEn    = wb_dat_i[CTRL_IRQ_EN];
				d.fastEdge = wb_dat_i[CTRL_FAST_EDGE];
				d.chgEn    = wb_dat_i[CTRL_CHG_EN];
				d.chgRes   = wb_dat_i[CTRL_RES_LSB +: 2];
				d.clkAuto  = wb_dat_i[CTRL_CLK_AUTO];
			end
			if (wb_sel_i[1]) begin
				d.tsSel = wb_dat_i[CTRL_TS_SEL];
			end
		end

		// Clear by writing one, only while running from main
		if (wrTake && wb_adr_i == STATUS_OFS && wb_sel_i[0]
		    && wb_dat_i[STAT_FLAG] && q.st == ST_MAIN) begin
			d.flag = 1'b0;
		end

		// Effective mode follows the register, delayed when waking up
		if (q.mode == q.effMode) begin
			d.reactCnt = '0;
		end else if (slowStart) begin
			if (q.reactCnt >= reactLim) begin
				d.effMode  = q.mode;
				d.reactCnt = '0;
			end else begin
				d.reactCnt = q.reactCnt + 1'b1;
			end
		end else begin
			// Dropping to off or standby, or moving between direct and level, needs no wait
			d.effMode  = q.mode;
			d.reactCnt = '0;
		end

		// Supply state machine
		case (q.st)
			ST_INIT: begin
				// Let the synchronizers fill before judging the supplies
				d.initCnt = q.initCnt + 1'b1;
				if (q.initCnt == SETTLE_CYC) begin
					// Judge the filtered level as it stands after this edge
					d.st = d.mLow ? ST_STANDBY : ST_MAIN;
				end
			end
			ST_MAIN: begin
				// Watch for standby entry or a switchover
				d.debCnt = '0;
				if (q.effMode == MODE_STANDBY && q.mLow) begin
					d.st = ST_STANDBY;
				end else if (switchCond) begin
					d.st   = ST_BACKUP;
					d.flag = 1'b1;
					d.ts   = q.tsSel;
				end
			end
			ST_BACKUP: begin
				// Any return of the condition restarts the debounce
				if (switchCond) begin
					d.debCnt = '0;
				end else if (q.debCnt == DEB_W'(DEB_CYC - 1)) begin
					d.st       = ST_MAIN;
					d.debCnt   = '0;
					d.clkStart = q.clkAuto;
				end else begin
					d.debCnt = q.debCnt + 1'b1;
				end
			end
			ST_STANDBY: begin
				// Leave only when main is back and a switching mode is set
				if (q.mLow || !q.effMode[0]) begin
					d.debCnt = '0;
				end else if (q.debCnt == DEB_W'(DEB_CYC - 1)) begin
					d.st     = ST_MAIN;
					d.debCnt = '0;
				end else begin
					d.debCnt = q.debCnt + 1'b1;
				end
			end
			default: begin
				// Unused encodings fall back to settling
				d.st = ST_INIT;
			end
		endcase

		// Flag is held low with switchover disabled
		// Placed last so that disabling wins over a set in the same cycle
		if (q.mode == MODE_OFF) begin
			d.flag = 1'b0;
		end

		// Registered outputs
		// Supply outputs are taken from the next state so they line up with it; irq is taken from the current flag and lags it by one cycle
		d.onBk  = (d.st == ST_BACKUP);
		d.stby  = (d.st == ST_STANDBY);
		d.irq   = (q.flag & q.irqEn) | otherIrq;
		d.clkPin = clkSource & ~d.onBk;
		// Charger runs only from main supply
		d.chgOn = q.chgEn & (d.st == ST_MAIN);
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			// Synchronizers restart empty; the settle count covers the refill
			q          <= '0;
			q.st       <= ST_INIT;
			q.mode     <= MODE_RST;
			q.effMode  <= MODE_RST;
			q.fastEdge <= FAST_RST;
			q.chgRes   <= RES_RST;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Every output is a plain copy of a register, so pins never glitch
	// Bus
	assign wb_dat_o       = q.rdat;
	assign wb_ack_o       = q.ack;

	// Interrupt and event path stay live on backup
	assign irqOut         = q.irq;
	assign eventLevel     = q.evt;

	// Gating while on backup
	assign clkOutPin      = q.clkPin;
	assign i2cHighZ       = q.onBk;
	assign i2cHoldReset   = q.onBk;

	// Supply status and pulses
	assign onBackup       = q.onBk;
	assign standby        = q.stby;
	assign tsTrigger      = q.ts;
	assign clkAutoStart   = q.clkStart;

	// Charger and configuration
	assign chargerOn      = q.chgOn;
	assign chargerRes     = q.chgRes;
	assign fastEdgeEnable = q.fastEdge;

endmodule : bss_switchover

`default_nettype wire

// [src/bss_pkg.sv]
/*
 * Constants and types shared by the backup supply switchover control block.
 * Assumes a 20 MHz reference clock and a 32-bit classic Wishbone register bus.
 */
`default_nettype none

package bss_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 50;
	localparam int DEB_MIN_NS     = 122000;
	localparam int DEB_MAX_NS     = 183000;
	localparam int DIR_REACT_NS   = 2000000;
	localparam int LVL_REACT_NS   = 15625000;
	// Least debounce rounds up, longest reaction times round down
	localparam int DEB_CYC        = (DEB_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DIR_REACT_CYC  = DIR_REACT_NS / CLK_PERIOD_NS;
	localparam int LVL_REACT_CYC  = LVL_REACT_NS / CLK_PERIOD_NS;
	localparam int DEB_W          = 12;
	localparam int REACT_W        = 19;
	localparam logic [1:0] SETTLE_CYC = 2'h3;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [3:0] CTRL_OFS   = 4'h0;
	localparam logic [3:0] STATUS_OFS = 4'h4;

	// Control fields
	localparam int CTRL_MODE_LSB  = 0;
	localparam int CTRL_IRQ_EN    = 2;
	localparam int CTRL_FAST_EDGE = 3;
	localparam int CTRL_CHG_EN    = 4;
	localparam int CTRL_RES_LSB   = 5;
	localparam int CTRL_CLK_AUTO  = 7;
	localparam int CTRL_TS_SEL    = 8;

	// Status fields
	localparam int STAT_FLAG      = 0;
	localparam int STAT_ON_BACKUP = 1;
	localparam int STAT_STANDBY   = 2;
	localparam int STAT_PENDING   = 3;
	localparam int STAT_EFF_LSB   = 4;
	localparam int STAT_EVENT     = 6;

	// Reset values
	localparam logic [1:0] MODE_RST  = 2'h0;
	localparam logic       FAST_RST  = 1'h1;
	localparam logic [1:0] RES_RST   = 2'h0;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_OFF,
		MODE_DIRECT,
		MODE_STANDBY,
		MODE_LEVEL
	} bss_mode_t;

	typedef enum logic [1:0] {
		ST_INIT,
		ST_MAIN,
		ST_BACKUP,
		ST_STANDBY
	} bss_state_t;

endpackage : bss_pkg

`default_nettype wire

// [testbench/bss_switchover_sva.sv]
/*
 * Port-level assertions for the backup supply switchover block.
 * Assumes one clock domain, ref_clk, with srst synchronous and active high.
 */
`default_nettype none

module bss_switchover_sva (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Bus handshake
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	// Comparators and pins
	input wire logic mainBelowBackup,
	input wire logic mainBelowThreshold,
	input wire logic backupAboveThreshold,
	input wire logic eventPin,
	input wire logic otherIrq,
	// Outputs watched
	input wire logic irqOut,
	input wire logic eventLevel,
	input wire logic clkOutPin,
	input wire logic i2cHighZ,
	input wire logic i2cHoldReset,
	input wire logic onBackup,
	input wire logic standby,
	input wire logic tsTrigger,
	input wire logic clkAutoStart,
	input wire logic chargerOn
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0]  rstAge_q;
	logic [11:0] quiet_q;

	// Cycles since reset, and cycles since all three comparators last gave the level-mode switch condition
	always_ff @(posedge ref_clk) begin
		rstAge_q <= srst ? 4'h0 : rstAge_q + {3'h0, rstAge_q != 4'hf};
		if (mainBelowBackup && mainBelowThreshold && backupAboveThreshold)
			quiet_q <= 12'h0;
		else
			quiet_q <= quiet_q + {11'h0, quiet_q != 12'hfff};
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered next cycle");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_i2c_gated: assert property (i2cHighZ == onBackup && i2cHoldReset == onBackup)
		else $error("serial gating differs from backup state");
	a_clk_low: assert property (onBackup && $past(onBackup) |-> !clkOutPin)
		else $error("clock pin active on backup");
	a_charger_off: assert property ((onBackup || standby) && $past(onBackup || standby) |-> !chargerOn)
		else $error("charger on while not on main");
	a_irq_live: assert property (otherIrq |=> irqOut)
		else $error("other interrupt lost");
	a_event_live: assert property (rstAge_q == 4'hf ##0 $stable(eventPin)[*8] |-> eventLevel == eventPin)
		else $error("event level does not follow pin");
	a_ts_entry: assert property (tsTrigger |-> ##[0:1] onBackup)
		else $error("time stamp trigger without backup entry");
	a_auto_clk: assert property (clkAutoStart |-> !onBackup && ($past(onBackup) || $past(onBackup, 2)))
		else $error("auto clock start without return");
	a_return_deb: assert property ($fell(onBackup) |-> quiet_q >= 12'd2430)
		else $error("return to main before debounce");

	c_backup: cover property ($rose(onBackup));
	c_standby: cover property ($rose(standby));
	c_ts: cover property (tsTrigger);
	c_auto: cover property (clkAutoStart);
endmodule : bss_switchover_sva

`default_nettype wire

// [testbench/bss_supply_model.sv]
/*
 * Supply comparator model: main, backup and threshold compare.
 * Assumes supply levels in millivolts from the testbench.
 */
`default_nettype none

module bss_supply_model #(
	parameter int THR_MV = 2000
) (
	// Supply levels
	input  wire logic [15:0] mainMv,
	input  wire logic [15:0] backupMv,
	// Comparator results
	output logic             mainBelowBackup,
	output logic             mainBelowThreshold,
	output logic             backupAboveThreshold
);
	timeunit 1ns;
	timeprecision 1ns;
	// Analog settling puts the edges off the clock, as a real comparator would
	assign #7 mainBelowBackup      = mainMv < backupMv;
	assign #7 mainBelowThreshold   = mainMv < 16'(THR_MV);
	assign #7 backupAboveThreshold = backupMv > 16'(THR_MV);
endmodule : bss_supply_model

`default_nettype wire

// [testbench/testbench.sv]
/*
 * Self-checking bench for the switchover block over classic Wishbone.
 * Assumes the supply model and the bound port checker.
 */
`default_nettype none

module testbench
	import bss_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DIR_D = 20;
	localparam int LVL_D = 40;
	logic ref_clk, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, otherIrq;
	logic        clkSource = 1'h0, eventPin = 1'h0;
	logic irqOut, eventLevel, clkOutPin, i2cHighZ, i2cHoldReset, onBackup, standby;
	logic tsTrigger, clkAutoStart, chargerOn, fastEdgeEnable;
	logic mainBelowBackup, mainBelowThreshold, backupAboveThreshold;
	logic [3:0]  wb_adr_i, wb_sel_i;
	logic [1:0]  chargerRes;
	logic [15:0] mainMv, backupMv;
	logic [31:0] wb_dat_i, wb_dat_o, rdat, rnd, ctl;
	int          seed = 16928;
	int          mismatches, checkCount, n;
	int          tsCount, autoCount;

	bss_switchover #(.DIR_DELAY(DIR_D), .LVL_DELAY(LVL_D)) dut (.ref_clk, .srst, .wb_cyc_i,
		.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.mainBelowBackup, .mainBelowThreshold, .backupAboveThreshold, .eventPin, .otherIrq,
		.clkSource, .irqOut, .eventLevel, .clkOutPin, .i2cHighZ, .i2cHoldReset, .onBackup,
		.standby, .tsTrigger, .clkAutoStart, .chargerOn, .chargerRes, .fastEdgeEnable);
	bss_supply_model supply (.mainMv, .backupMv, .mainBelowBackup, .mainBelowThreshold,
		.backupAboveThreshold);

	initial begin
		ref_clk = 1'h0;
		forever #25 ref_clk = ~ref_clk;
	end

	// Random clock source and occasional event edges; one-cycle pulses are counted
	always @(posedge ref_clk) begin
		rnd <= $random(seed);
		clkSource <= rnd[0];
		if (rnd[7:2] == 6'h0) eventPin <= ~eventPin;
		if (tsTrigger) tsCount <= tsCount + 1;
		if (clkAutoStart) autoCount <= autoCount + 1;
	end

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", checkCount, mismatches);
		if (mismatches == 0 && checkCount > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_of_test

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		checkCount++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int k;
		@(posedge ref_clk);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, w, a, 4'hf, d};
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (wb_ack_o !== 1'h1 && k < 20);
		rdat = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'h0;
		if (k >= 20) begin
			mismatches++;
			end_of_test();
		end
	endtask : bus

	// Bounded wait for the backup or standby output to reach a level
	task automatic waitFor(input logic lvl, input logic sb, input int lim);
		n = 0;
		while ((sb ? standby : onBackup) !== lvl && n < lim) begin
			@(posedge ref_clk);
			n++;
		end
		if (n >= lim) begin
			mismatches++;
			end_of_test();
		end
	endtask : waitFor

	initial begin
		{srst, wb_cyc_i, wb_stb_i, wb_we_i, otherIrq} = 5'h10;
		{wb_adr_i, wb_sel_i, wb_dat_i} = 40'h0;
		mainMv = 16'd3300;
		backupMv = 16'd3000;
		repeat (16) @(posedge ref_clk);
		srst <= 1'h0;
		repeat (8) @(posedge ref_clk);
		check(fastEdgeEnable, 1, "fast edge reset");
		bus(0, CTRL_OFS, 0);
		check(rdat, 32'h8, "control reset");
		bus(0, 4'h8, 0);
		check(rdat, 0, "unmapped read");
		$display("test reset done");
		ctl = {23'h0, 2'h3, rnd[1:0], 3'h7, 2'h1};
		bus(1, CTRL_OFS, ctl);
		repeat (3) @(posedge ref_clk);
		check({chargerOn, chargerRes}, {1'h1, ctl[6:5]}, "charger on main");
		mainMv <= 16'd1000;
		waitFor(1, 0, DIR_D + 12);
		repeat (2) @(posedge ref_clk);
		check({i2cHighZ, i2cHoldReset, clkOutPin, chargerOn, irqOut}, 5'h19, "backup");
		bus(1, STATUS_OFS, 1);
		bus(0, STATUS_OFS, 0);
		check(rdat[1:0], 2'h3, "flag kept on backup");
		mainMv <= 16'd3300;
		waitFor(0, 0, 4000);
		check(n >= 2440 && n <= 3700, 1, "return delay");
		// First access after a return starts from an idle bus, as after stop and start
		bus(1, STATUS_OFS, 1);
		bus(0, STATUS_OFS, 0);
		check(rdat[0], 0, "flag cleared on main");
		check(irqOut, 0, "interrupt released");
		$display("test direct done");
		bus(1, CTRL_OFS, 32'h8);
		mainMv <= 16'd1000;
		repeat (100) @(posedge ref_clk);
		bus(0, STATUS_OFS, 0);
		check(rdat[1:0], 0, "disabled mode");
		mainMv <= 16'd3300;
		bus(1, CTRL_OFS, 32'hb);
		mainMv <= 16'd2500;
		repeat (LVL_D + 40) @(posedge ref_clk);
		check(onBackup, 0, "level above threshold");
		mainMv <= 16'd1500;
		waitFor(1, 0, 20);
		otherIrq <= 1'h1;
		repeat (3) @(posedge ref_clk);
		check(irqOut, 1, "other interrupt on backup");
		otherIrq <= 1'h0;
		repeat (3) @(posedge ref_clk);
		check(irqOut, 0, "flag without enable");
		mainMv <= 16'd3300;
		waitFor(0, 0, 4000);
		$display("test level done");
		bus(1, CTRL_OFS, 32'h1a);
		mainMv <= 16'd0;
		waitFor(1, 1, 40);
		check({onBackup, chargerOn}, 0, "standby draws nothing");
		srst <= 1'h1;
		repeat (16) @(posedge ref_clk);
		srst <= 1'h0;
		waitFor(1, 1, 20);
		check(tsCount, 1, "time stamp pulses");
		check(autoCount, 1, "clock auto start pulses");
		$display("test standby done");
		end_of_test();
	end
endmodule : testbench

bind bss_switchover bss_switchover_sva chk (.ref_clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
	.mainBelowBackup, .mainBelowThreshold, .backupAboveThreshold, .eventPin, .otherIrq, .irqOut,
	.eventLevel, .clkOutPin, .i2cHighZ, .i2cHoldReset, .onBackup, .standby, .tsTrigger,
	.clkAutoStart, .chargerOn);

`default_nettype wire
